// [hdl/pss_defines.vh]
// Constants for the PHY status summary block: offsets, field positions,
// reset values and counter limits. Assumes inclusion by bare name.
`ifndef PSS_DEFINES_VH
`define PSS_DEFINES_VH
`define PSS_OFF_SUMMARY 12'h0c0
`define PSS_OFF_FCC 12'h0d0
`define PSS_OFF_REC 12'h0d4
`define PSS_OFF_IRQ_STAT 12'h0e0
`define PSS_OFF_IRQ_MASK 12'h0e4
`define PSS_OFF_SRC_RD 12'h0e8
`define PSS_SUMMARY_RST 16'h0000
`define PSS_BIT_RXERR 13
`define PSS_BIT_POL 12
`define PSS_BIT_FCS 11
`define PSS_BIT_SD 10
`define PSS_BIT_LOCK 9
`define PSS_BIT_PAGE 8
`define PSS_BIT_MINT 7
`define PSS_BIT_RF 6
`define PSS_BIT_JAB 5
`define PSS_BIT_ANC 4
`define PSS_BIT_LPBK 3
`define PSS_BIT_DUP 2
`define PSS_BIT_SPD 1
`define PSS_BIT_LINK 0
`define PSS_CNT_MAX 8'hff
`define PSS_IRQ_W 4
`define PSS_SYNC_W 8
`endif

// [hdl/pss_sync.v]
// Two-flop synchroniser bank for the mirrored PHY status inputs.
// Assumes ref_clk and the active-low asynchronous reset nrst.
`timescale 1ns/1ns
module pss_sync #(
	parameter W = 11
) (
	input wire ref_clk,
	input wire nrst,
	input wire [W-1:0] d_in,
	output reg [W-1:0] q_out
);
	reg [W-1:0] meta_r;

	// First stage feeds only the second stage.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			meta_r <= {W{1'b0}};
			q_out <= {W{1'b0}};
		end else begin
			meta_r <= d_in;
			q_out <= meta_r;
		end
	end
endmodule // pss_sync

// [hdl/pss_top.v]
// PHY status summary register with its error counters, behind an APB slave.
// Assumes all PHY status inputs arrive from outside ref_clk's domain.
// Function
// - Read-only 16-bit summary at 0xc0, resets to zero.
// - Bits 15:14 reserved, read zero, writes ignored.
// - Bit 13 latches receive errors, clears on error counter read.
// - Bit 12 mirrors inverted polarity, not cleared by summary read.
// - Bit 11 latches false carrier, clears on false carrier counter read.
// - Bit 10 is latch-low signal detect, reset zero.
// - Bit 9 is latch-low descrambler lock, reset zero.
// - Bit 8 mirrors page received, not cleared by summary read.
// - Bit 7 latches pending interrupt, cleared by the summary read.
// - Bit 6 latches remote fault, clears on basic status read.
// - Bit 5 mirrors jabber detect, not cleared by summary read.
// - Bit 4 shows auto-negotiation complete.
// - Bit 3 shows loopback enabled.
// - Bit 2 shows full duplex when one.
// - Bit 1 shows 10 Mb/s when one, 100 Mb/s when zero.
// - Bit 0 mirrors link status, not cleared by summary read.
// - Receive error count once per carrier, none in collision, saturates.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ns
`include "pss_defines.vh"
module pss_top (
	input wire ref_clk,
	input wire nrst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire rx_carrier,
	input wire rx_symbol_err,
	input wire rx_collision,
	input wire false_carrier,
	input wire polarity_inv,
	input wire signal_detect,
	input wire descr_lock,
	input wire page_rx,
	input wire phy_int,
	input wire remote_fault,
	input wire jabber,
	input wire an_complete,
	input wire loopback_en,
	input wire full_duplex,
	input wire speed_10,
	input wire link_ok,
	output reg src_rd_basic_status,
	output reg src_rd_tenbase_t,
	output reg src_rd_autoneg_exp,
	output reg irq
);
	// Synchronised copies of the asynchronous status inputs.
	wire [`PSS_SYNC_W-1:0] raw_in;
	wire [`PSS_SYNC_W-1:0] s;
	wire s_pol;
	wire s_page;
	wire s_jab;
	wire s_anc;
	wire s_lpbk;
	wire s_dup;
	wire s_spd;
	wire s_link;
	reg s_car_r;
	reg s_err_r;
	reg s_col_r;
	reg s_fc_r;
	reg s_sd_r;
	reg s_lock_r;
	reg s_int_r;
	reg s_rf_r;
	reg fc_prev_r;
	reg err_seen_r;

	// Latches and counters.
	reg rxerr_r;
	reg fcs_r;
	reg mint_r;
	reg rf_r;
	reg [7:0] rec_cnt_r;
	reg [7:0] fcc_cnt_r;
	reg [`PSS_IRQ_W-1:0] irq_stat_r;
	reg [`PSS_IRQ_W-1:0] irq_mask_r;

	wire access;
	wire rd;
	wire wr;
	wire rd_sum;
	wire rd_rec;
	wire rd_fcc;
	wire rd_basic;
	wire wr_src;
	wire [1:0] ll_src;
	wire [1:0] ll_q;
	wire [15:0] summary;
	wire fc_evt;
	wire err_evt;
	wire [`PSS_IRQ_W-1:0] irq_evt;
	reg [31:0] rdata_nxt;
	reg slverr_nxt;

	// Mirrored status inputs use a two-flop synchroniser bank.
	assign raw_in = {polarity_inv, page_rx, jabber, an_complete,
		loopback_en, full_duplex, speed_10, link_ok};
	pss_sync #(.W(`PSS_SYNC_W)) u_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.d_in(raw_in),
		.q_out(s)
	);
	assign s_pol = s[7];
	assign s_page = s[6];
	assign s_jab = s[5];
	assign s_anc = s[4];
	assign s_lpbk = s[3];
	assign s_dup = s[2];
	assign s_spd = s[1];
	assign s_link = s[0];

	// Event inputs get their own two-flop stages so edges can be seen.
	reg [7:0] ev_meta_r;
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ev_meta_r <= 8'h00;
			{s_car_r, s_err_r, s_col_r, s_fc_r} <= 4'h0;
			{s_sd_r, s_lock_r, s_int_r, s_rf_r} <= 4'h0;
		end else begin
			ev_meta_r <= {rx_carrier, rx_symbol_err, rx_collision,
				false_carrier, signal_detect, descr_lock, phy_int,
				remote_fault};
			{s_car_r, s_err_r, s_col_r, s_fc_r, s_sd_r, s_lock_r, s_int_r,
				s_rf_r} <= ev_meta_r;
		end
	end

	// Compares the bus address against one register offset.
	function addr_hit;
		input [11:0] addr;
		input [11:0] off;
		begin
			addr_hit = (addr == off);
		end
	endfunction

	// APB decode. A request is taken once, in its first access cycle; the
	// second access cycle, with pready high, must not repeat a read-clear
	// or a write-one-to-clear, or an event landing between them is lost.
	assign access = psel && penable && !pready;
	assign rd = access && !pwrite;
	assign wr = access && pwrite;
	assign rd_sum = rd && addr_hit(paddr, `PSS_OFF_SUMMARY);
	assign rd_rec = rd && addr_hit(paddr, `PSS_OFF_REC);
	assign rd_fcc = rd && addr_hit(paddr, `PSS_OFF_FCC);
	assign wr_src = wr && addr_hit(paddr, `PSS_OFF_SRC_RD);
	assign rd_basic = wr_src && pwdata[0];

	// Events: rising false carrier, and one error per carrier event.
	assign fc_evt = s_fc_r && !fc_prev_r;
	assign err_evt = s_car_r && s_err_r && !s_col_r && !err_seen_r;

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fc_prev_r <= 1'b0;
			err_seen_r <= 1'b0;
		end else begin
			fc_prev_r <= s_fc_r;
			if (!s_car_r)
				err_seen_r <= 1'b0;
			else if (err_evt)
				err_seen_r <= 1'b1;
		end
	end

	// Counters saturate; a read clears, but an event in the same cycle wins.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rec_cnt_r <= 8'h00;
			fcc_cnt_r <= 8'h00;
		end else begin
			if (err_evt)
				rec_cnt_r <= rd_rec ? 8'h01 :
					(rec_cnt_r == `PSS_CNT_MAX ? rec_cnt_r :
					rec_cnt_r + 8'h01);
			else if (rd_rec)
				rec_cnt_r <= 8'h00;
			if (fc_evt)
				fcc_cnt_r <= rd_fcc ? 8'h01 :
					(fcc_cnt_r == `PSS_CNT_MAX ? fcc_cnt_r :
					fcc_cnt_r + 8'h01);
			else if (rd_fcc)
				fcc_cnt_r <= 8'h00;
		end
	end

	// Summary latches; set beats clear in the same cycle.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rxerr_r <= 1'b0;
			fcs_r <= 1'b0;
			mint_r <= 1'b0;
			rf_r <= 1'b0;
		end else begin
			if (err_evt)
				rxerr_r <= 1'b1;
			else if (rd_rec)
				rxerr_r <= 1'b0;
			if (fc_evt)
				fcs_r <= 1'b1;
			else if (rd_fcc)
				fcs_r <= 1'b0;
			if (s_int_r)
				mint_r <= 1'b1;
			else if (rd_sum)
				mint_r <= 1'b0;
			if (s_rf_r)
				rf_r <= 1'b1;
			else if (rd_basic)
				rf_r <= 1'b0;
		end
	end

	// Latch-low bits, signal detect above descrambler lock. A drop holds
	// zero until a summary read re-arms the bit; a drop in the same cycle
	// as the read wins, so a short loss of signal is never missed.
	assign ll_src = {s_sd_r, s_lock_r};
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_latch_low
			reg hold_r;
			always @(posedge ref_clk or negedge nrst) begin
				if (!nrst)
					hold_r <= 1'b0;
				else if (!ll_src[g])
					hold_r <= 1'b0;
				else if (rd_sum)
					hold_r <= 1'b1;
			end
			assign ll_q[g] = hold_r;
		end
	endgenerate

	// Summary word; mirrors are taken live from their sources.
	assign summary = {2'b00,
		rxerr_r, s_pol, fcs_r, ll_q[1], ll_q[0], s_page,
		mint_r, rf_r, s_jab, s_anc,
		s_lpbk, s_dup, s_spd, s_link};

	// Interrupt events: receive error, false carrier, remote fault; bit 0
	// is a spare that never sets.
	assign irq_evt = {err_evt, fc_evt, s_rf_r && !rf_r, 1'b0};

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat_r <= {`PSS_IRQ_W{1'b0}};
			irq_mask_r <= {`PSS_IRQ_W{1'b0}};
		end else begin
			if (wr && addr_hit(paddr, `PSS_OFF_IRQ_MASK))
				irq_mask_r <= pwdata[`PSS_IRQ_W-1:0];
			if (wr && addr_hit(paddr, `PSS_OFF_IRQ_STAT))
				irq_stat_r <= (irq_stat_r & ~pwdata[`PSS_IRQ_W-1:0]) | irq_evt;
			else
				irq_stat_r <= irq_stat_r | irq_evt;
		end
	end

	// Read mux; a write to the summary is ignored without error.
	always @* begin
		rdata_nxt = 32'h0000_0000;
		slverr_nxt = 1'b0;
		case (paddr)
		`PSS_OFF_SUMMARY: rdata_nxt = {16'h0000, summary};
		`PSS_OFF_REC: rdata_nxt = {24'h000000, rec_cnt_r};
		`PSS_OFF_FCC: rdata_nxt = {24'h000000, fcc_cnt_r};
		`PSS_OFF_IRQ_STAT: rdata_nxt = {28'h0000000, irq_stat_r};
		`PSS_OFF_IRQ_MASK: rdata_nxt = {28'h0000000, irq_mask_r};
		`PSS_OFF_SRC_RD: rdata_nxt = 32'h0000_0000;
		default: slverr_nxt = 1'b1;
		endcase
	end

	// Registered APB answer: pready rises one cycle into the access phase.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			src_rd_basic_status <= 1'b0;
			src_rd_tenbase_t <= 1'b0;
			src_rd_autoneg_exp <= 1'b0;
			irq <= 1'b0;
		end else begin
			pready <= access;
			prdata <= rd ? rdata_nxt : 32'h0000_0000;
			pslverr <= access && slverr_nxt;
			// Source-read strobes last one cycle, alongside pready.
			src_rd_basic_status <= rd_basic;
			src_rd_tenbase_t <= wr_src && pwdata[1];
			src_rd_autoneg_exp <= wr_src && pwdata[2];
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end
endmodule // pss_top

// [verification/pss_chk_props.sv]
// Checker for the status summary block: bus answer timing and mirror bits.
// Assumes it is bound into pss_top and sees only that module's ports.
`timescale 1ns/1ns
module pss_chk (
	input wire ref_clk,
	input wire nrst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire link_ok,
	input wire an_complete,
	input wire loopback_en,
	input wire full_duplex,
	input wire speed_10
);
	// A completed read of the summary word.
	wire rd_sum = pready && !pwrite && paddr == 12'h0c0;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// The link, speed, duplex, loopback and autoneg inputs are held for seven samples so the synchroniser settles.
	answer_time_a: assert property (
		psel && penable && !pready |=> pready) else $error("answer late");
	summary_mapped_a: assert property (
		pready && paddr == 12'h0c0 |-> !pslverr) else $error("summary refused");
	rsv_zero_a: assert property (
		rd_sum |-> prdata[31:14] == 18'h0) else $error("reserved bits set");
	link_mirror_a: assert property (
		$stable(link_ok)[*7] ##0 rd_sum |-> prdata[0] == link_ok)
		else $error("link bit wrong");
	speed_mirror_a: assert property (
		$stable(speed_10)[*7] ##0 rd_sum |-> prdata[1] == speed_10)
		else $error("speed bit wrong");
	duplex_mirror_a: assert property (
		$stable(full_duplex)[*7] ##0 rd_sum |-> prdata[2] == full_duplex)
		else $error("duplex bit wrong");
	lpbk_mirror_a: assert property (
		$stable(loopback_en)[*7] ##0 rd_sum |-> prdata[3] == loopback_en)
		else $error("loopback bit wrong");
	anc_mirror_a: assert property (
		$stable(an_complete)[*7] ##0 rd_sum |-> prdata[4] == an_complete)
		else $error("autoneg bit wrong");
endmodule // pss_chk
bind pss_top pss_chk pss_chk_i (.*);

// [verification/tb_phy_status_summary_register.sv]
// Bench for the status summary block: APB reads, PHY events, interrupt.
// Assumes pss_top with its checker bound; one 50 MHz clock.
`timescale 1ns/1ns
module tb_phy_status_summary_register;
	logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, irq, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic src_rd_basic_status, src_rd_tenbase_t, src_rd_autoneg_exp;
	logic rx_carrier, rx_symbol_err, rx_collision, false_carrier;
	logic polarity_inv, signal_detect, descr_lock, page_rx, phy_int;
	logic remote_fault, jabber, an_complete, loopback_en, full_duplex;
	logic speed_10, link_ok;
	logic [15:0] ph;
	logic [2:0] s;
	integer err_total, compares, i;
	// The stimulus vector spreads onto the PHY status inputs.
	assign {rx_carrier, rx_symbol_err, rx_collision, false_carrier,
		polarity_inv, signal_detect, descr_lock, page_rx, phy_int,
		remote_fault, jabber, an_complete, loopback_en, full_duplex,
		speed_10, link_ok} = ph;
	pss_top pss_top_i (.*);
	// Free-running 50 MHz clock.
	initial begin
		ref_clk = 1'h0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Cuts a hang short.
	initial begin
		repeat (9000) @(posedge ref_clk);
		err_total++;
		$display("unexpected %0t timeout", $time);
		conclude;
	end
	task w(input integer n);
		repeat (n) @(posedge ref_clk);
	endtask
	task conclude;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task ck(input [31:0] g, input [31:0] x);
		compares++;
		if (g !== x) begin
			err_total++;
			$display("unexpected %0t got %h want %h", $time, g, x);
		end
	endtask
	// One APB transfer; read data and error land in q and e.
	task xf(input wr, input [11:0] a, input [31:0] d);
		integer n;
		begin
			@(posedge ref_clk);
			psel <= 1'h1;
			pwrite <= wr;
			paddr <= a;
			pwdata <= d;
			@(posedge ref_clk);
			penable <= 1'h1;
			n = 0;
			do begin
				@(posedge ref_clk);
				n++;
			end while (pready !== 1'h1 && n < 20);
			if (n >= 20) begin
				err_total++;
				$display("unexpected %0t no answer", $time);
				conclude;
			end
			q = prdata;
			e = pslverr;
			s = {src_rd_autoneg_exp, src_rd_tenbase_t,
				src_rd_basic_status};
			psel <= 1'h0;
			penable <= 1'h0;
		end
	endtask
	task rs;
		xf(1'h0, 12'h0c0, 32'h0);
	endtask
	task pulse(input integer b, input integer n);
		repeat (n) begin
			ph[b] <= 1'h1;
			w(3);
			ph[b] <= 1'h0;
			w(3);
		end
	endtask
	function [31:0] ex(input [15:0] p);
		ex = {19'h0, p[11], 1'h0, p[10:8], 2'h0, p[5:0]};
	endfunction
	// Main sequence.
	initial begin
		err_total = 0;
		compares = 0;
		{nrst, psel, penable, pwrite, paddr, pwdata, ph} = 64'h0;
		void'($urandom(32'he270));
		w(4);
		nrst <= 1'h1;
		// Reset value, an ignored write and an unmapped address.
		rs;
		ck(q, 32'h0);
		ck(e, 1'h0);
		xf(1'h1, 12'h0c0, 32'hffff);
		ck(s, 3'h0);
		rs;
		ck(q, 32'h0);
		xf(1'h0, 12'h0f0, 32'h0);
		ck(q, 32'h0);
		ck(e, 1'h1);
		// Latch-low bits start low and re-arm only on a summary read.
		ph[10:9] <= 2'h3;
		w(5);
		rs;
		ck(q[10:9], 2'h0);
		rs;
		ck(q[10:9], 2'h3);
		ph[10:9] <= 2'h0;
		w(4);
		ph[10:9] <= 2'h3;
		w(5);
		rs;
		ck(q[10:9], 2'h0);
		rs;
		ck(q[10:9], 2'h3);
		// Random mirror values, all ones and all zeros first.
		for (i = 0; i < 12; i++) begin
			q = $urandom;
			if (i == 0)
				q = 32'hffff_ffff;
			if (i == 1)
				q = 32'h0;
			ph <= {4'h0, q[11], 2'h3, q[8], 2'h0, q[5:0]};
			w(5);
			rs;
			ck(q, ex(ph));
			if (q[0] && q[4])
				ck(q[2:1], ph[2:1]);
			rs;
			ck(q, ex(ph));
		end
		ph <= 16'h0;
		w(5);
		pulse(7, 1);
		rs;
		ck(q[7], 1'h1);
		rs;
		ck(q[7], 1'h0);
		pulse(6, 1);
		rs;
		rs;
		ck(q[6], 1'h1);
		xf(1'h1, 12'h0e8, 32'h1);
		ck(s, 3'h1);
		rs;
		ck(q[6], 1'h0);
		ck(s, 3'h0);
		xf(1'h1, 12'h0e8, 32'h6);
		ck(s, 3'h6);
		// Two errors in one carrier, then one error during a collision.
		ph[15] <= 1'h1;
		w(1);
		pulse(14, 2);
		ph[15] <= 1'h0;
		w(5);
		rs;
		ck(q[13], 1'h1);
		ph[15:13] <= 3'h5;
		w(1);
		pulse(14, 1);
		ph[15:13] <= 3'h0;
		w(5);
		xf(1'h0, 12'h0d4, 32'h0);
		ck(q, 32'h1);
		rs;
		ck(q[13], 1'h0);
		pulse(12, 300);
		rs;
		ck(q[11], 1'h1);
		xf(1'h0, 12'h0d0, 32'h0);
		ck(q, 32'hff);
		rs;
		ck(q[11], 1'h0);
		ck(irq, 1'h0);
		xf(1'h1, 12'h0e4, 32'h4);
		w(2);
		ck(irq, 1'h1);
		xf(1'h1, 12'h0e0, 32'h4);
		w(2);
		ck(irq, 1'h0);
		conclude;
	end
endmodule // tb_phy_status_summary_register
